// ---- ipcr_config_regs.sv ----
// Plug and play card and logical device configuration registers
`timescale 1ns/100ps
module ipcr_config_regs
  import ipcr_pkg::*;
#(
  // Serial identifier; the value is arbitrary
  parameter logic [SERIAL_BITS-1:0] SERIAL_ID = 72'h3C_0000_0001_1234_5678,
  // Bytes that follow the identifier in the resource data
  parameter logic [15:0]            RES_TAIL  = 16'h0079,
  parameter int                     RES_FETCH = RES_FETCH_CYC
) (
  // Clock and reset
  input  logic             i_clock,
  input  logic             i_rst,
  // ISA bus pins
  input  ipcr_isa_in_type  i_isa,
  output ipcr_isa_out_type o_isa,
  // Configuration outputs
  output ipcr_state_type   o_card_state,
  output logic             o_device_active,
  output logic [7:0]       o_boot_rom_base_hi,
  output logic [7:0]       o_boot_rom_base_lo,
  output logic [7:0]       o_io_base_hi,
  output logic [7:0]       o_io_base_lo
);
  localparam int          RES_LEN  = SERIAL_BITS / 8 + 2;
  localparam logic [6:0]  ISO_LAST = 7'(SERIAL_BITS - 1);

  if (SERIAL_BITS > 128 || RES_FETCH < 1) begin : g_bad
    $error("serial length or fetch time out of range");
  end

  ipcr_isa_in_type sync1_r;
  ipcr_isa_in_type sync2_r;
  logic            ior3_r;
  logic            iow3_r;

  ipcr_state_type  state_r;
  ipcr_state_type  state_nxt;
  logic [7:0]      idx_r;
  logic [7:0]      rd_port_r;
  logic [7:0]      csn_r;
  logic            act_r;
  logic [1:0]      rc_r;
  logic [7:0]      rom_hi_r;
  logic [7:0]      rom_lo_r;
  logic [7:0]      io_hi_r;
  logic [7:0]      io_lo_r;
  logic [6:0]      iso_idx_r;
  logic            iso_second_r;
  logic            iso_heard_r;
  logic [7:0]      out_data_r;
  logic            out_oe_n_r;
  logic [7:0]      rd_val;
  logic            key_ok;
  logic [7:0]      res_byte;
  logic            res_ready;

  // Every pin passes two flops; edges are taken on the second stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync1_r <= ISA_IDLE;
      sync2_r <= ISA_IDLE;
      ior3_r  <= 1'b1;
      iow3_r  <= 1'b1;
    end else begin
      sync1_r <= i_isa;
      sync2_r <= sync1_r;
      ior3_r  <= sync2_r.ior_n;
      iow3_r  <= sync2_r.iow_n;
    end
  end

  // Writes take effect at the end of the strobe, when data is stable
  wire iow_rise = sync2_r.iow_n && !iow3_r;
  wire ior_fall = !sync2_r.ior_n && ior3_r;
  wire ior_rise = sync2_r.ior_n && !ior3_r;
  wire [7:0] din = sync2_r.data;

  wire waiting = state_r == ST_WAIT_KEY;
  wire in_cfg  = state_r == ST_CONFIG;
  wire in_iso  = state_r == ST_ISOLATION;

  // Ports stay dead until the key has been seen
  wire wr_addr = iow_rise && sync2_r.addr == ADDR_PORT;
  wire wr_data = iow_rise && sync2_r.addr == WDATA_PORT && !waiting;
  wire [11:0] rd_port_addr = {ISA_TOP_ZERO, rd_port_r, RD_PORT_LSB};
  wire rd_hit  = sync2_r.addr == rd_port_addr && !waiting;

  wire ctrl_wr  = wr_data && idx_r == IDX_CTRL;
  // Commands are pulses, never stored, so they need no clearing
  wire cmd_reset = ctrl_wr && din[CTRL_RESET_BIT];
  wire cmd_wfk   = ctrl_wr && din[CTRL_WFK_BIT];
  wire cmd_csn0  = ctrl_wr && din[CTRL_CSN_BIT];
  wire wake_hit  = wr_data && idx_r == IDX_WAKE
                   && state_r == ST_SLEEP && din == csn_r;
  wire csn_wr    = wr_data && idx_r == IDX_CSN
                   && (in_iso || in_cfg);
  wire cfg_wr    = wr_data && in_cfg;

  // Range check is honoured only while the device is off
  wire range_on  = rc_r[RC_EN_BIT] && !act_r;
  wire [4:0] io_win = {IO_HI_FIXED[1], io_hi_r[0], io_lo_r[7:5]};
  wire range_hit = range_on && sync2_r.addr[11:10] == ISA_TOP_ZERO
                   && sync2_r.addr[9:5] == io_win;

  wire iso_read = rd_hit && idx_r == IDX_SER_ISO && in_iso;
  wire iso_bit  = SERIAL_ID[iso_idx_r];
  wire iso_rise = ior_rise && iso_read;
  wire iso_lose = iso_rise && iso_second_r && !iso_bit && iso_heard_r
                  && din[1:0] == SENSE_SECOND;

  wire [7:0] rc_pat  = rc_r[RC_SEL_BIT] ? PAT_55 : PAT_AA;
  wire [7:0] iso_pat = iso_second_r ? PAT_AA : PAT_55;
  // A zero serial bit leaves the bus floating so others can be sensed
  wire drv_cfg   = rd_hit && !(iso_read && !iso_bit);
  wire drive_set = ior_fall && (drv_cfg || range_hit);
  wire [7:0] drive_val = !rd_hit ? rc_pat
                       : iso_read ? iso_pat : rd_val;

  wire res_adv = ior_rise && rd_hit && idx_r == IDX_RES_DATA && in_cfg;

  // Index read selection; anything undefined reads zero
  always_comb begin
    unique case (idx_r)
      IDX_RES_DATA: rd_val = res_byte;
      IDX_STATUS:   rd_val = {7'h00, res_ready};
      IDX_CSN:      rd_val = csn_r;
      IDX_LDN:      rd_val = LDN_VALUE;
      IDX_ACTIVATE: rd_val = {7'h00, act_r};
      IDX_RANGE:    rd_val = {6'h00, rc_r};
      IDX_ROM_HI:   rd_val = rom_hi_r;
      IDX_ROM_LO:   rd_val = rom_lo_r;
      IDX_MEM_CTRL: rd_val = MEM_CTRL_VALUE;
      IDX_IO_HI:    rd_val = io_hi_r | IO_HI_FIXED;
      IDX_IO_LO:    rd_val = io_lo_r;
      default:      rd_val = READ_ZERO;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    if (key_ok) begin
      state_nxt = ST_SLEEP;
    end else if (cmd_wfk) begin
      state_nxt = ST_WAIT_KEY;
    end else if (wake_hit) begin
      state_nxt = din == 8'h00 ? ST_ISOLATION : ST_CONFIG;
    end else if (csn_wr && in_iso) begin
      state_nxt = ST_CONFIG;
    end else if (iso_lose) begin
      state_nxt = ST_SLEEP;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= ST_WAIT_KEY;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      idx_r <= IDX_RST;
    end else if (wr_addr && !waiting) begin
      idx_r <= din;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rd_port_r <= RDPORT_RST;
    end else if (wr_data && idx_r == IDX_RD_PORT) begin
      rd_port_r <= din;
    end
  end

  // The device reset command leaves the card number alone
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      csn_r <= CSN_RST;
    end else if (cmd_csn0) begin
      csn_r <= CSN_RST;
    end else if (csn_wr) begin
      csn_r <= din;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || cmd_reset) begin
      act_r    <= ACT_RST;
      rc_r     <= RC_RST;
      rom_hi_r <= ROM_RST;
      rom_lo_r <= ROM_RST;
      io_hi_r  <= IO_RST;
      io_lo_r  <= IO_RST;
    end else if (cfg_wr) begin
      unique case (idx_r)
        IDX_ACTIVATE: act_r    <= din[0];
        IDX_RANGE:    rc_r     <= din[1:0];
        IDX_ROM_HI:   rom_hi_r <= din & ROM_HI_WMASK;
        IDX_ROM_LO:   rom_lo_r <= din & ROM_LO_WMASK;
        IDX_IO_HI:    io_hi_r  <= din & IO_HI_WMASK;
        IDX_IO_LO:    io_lo_r  <= din & IO_LO_WMASK;
        default:      act_r    <= act_r;
      endcase
    end
  end

  // Isolation walks the identifier one bit per read pair
  always_ff @(posedge i_clock) begin
    if (i_rst || wake_hit || key_ok) begin
      iso_idx_r    <= 7'h00;
      iso_second_r <= 1'b0;
      iso_heard_r  <= 1'b0;
    end else if (iso_rise && !iso_second_r) begin
      iso_second_r <= 1'b1;
      iso_heard_r  <= !iso_bit && din[1:0] == SENSE_FIRST;
    end else if (iso_rise) begin
      iso_second_r <= 1'b0;
      iso_heard_r  <= 1'b0;
      if (!iso_lose && iso_idx_r != ISO_LAST) begin
        iso_idx_r <= iso_idx_r + 7'h01;
      end
    end
  end

  // Data is held from the start of the read strobe to its end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_data_r <= READ_ZERO;
      out_oe_n_r <= 1'b1;
    end else if (ior_rise) begin
      out_oe_n_r <= 1'b1;
    end else if (drive_set) begin
      out_data_r <= drive_val;
      out_oe_n_r <= 1'b0;
    end
  end

  ipcr_key_detect u_key (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_wr     (wr_addr && waiting),
    .i_data   (din),
    .o_key_ok (key_ok)
  );

  ipcr_res_reader #(
    .RES_LEN   (RES_LEN),
    .RES_IMAGE ({RES_TAIL, SERIAL_ID}),
    .FETCH_CYC (RES_FETCH)
  ) u_res (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_restart (wake_hit || key_ok),
    .i_advance (res_adv),
    .o_byte    (res_byte),
    .o_ready   (res_ready)
  );

  assign o_isa.data         = out_data_r;
  assign o_isa.oe_n         = out_oe_n_r;
  assign o_card_state       = state_r;
  assign o_device_active    = act_r;
  assign o_boot_rom_base_hi = rom_hi_r;
  assign o_boot_rom_base_lo = rom_lo_r;
  assign o_io_base_hi       = io_hi_r;
  assign o_io_base_lo       = io_lo_r;

  chk_rdport_decode: assert property (@(posedge i_clock) disable iff (i_rst)
    ior_fall && !waiting && !range_hit
    && sync2_r.addr[1:0] != RD_PORT_LSB |=> out_oe_n_r)
    else $error("read port answered with low address bits not set");

  chk_ctrl_reset: assert property (@(posedge i_clock) disable iff (i_rst)
    cmd_reset && !cmd_csn0 |=> !act_r && rc_r == RC_RST
    && io_lo_r == IO_RST && $stable(csn_r))
    else $error("reset command left registers or changed card number");

  chk_ctrl_wfk: assert property (@(posedge i_clock) disable iff (i_rst)
    cmd_wfk && !cmd_csn0 |=> state_r == ST_WAIT_KEY
    && $stable(csn_r))
    else $error("wait-for-key command not obeyed");

  chk_csn_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    cmd_csn0 |=> csn_r == CSN_RST ##1 csn_r == CSN_RST || $past(csn_wr))
    else $error("card number not cleared");

  chk_wake_move: assert property (@(posedge i_clock) disable iff (i_rst)
    wake_hit && !cmd_wfk |=> state_r == ($past(din) == 8'h00
    ? ST_ISOLATION : ST_CONFIG))
    else $error("wake command went to the wrong state");

  chk_wake_ignore: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_data && idx_r == IDX_WAKE && din != csn_r
    && state_r == ST_SLEEP |=> state_r == ST_SLEEP)
    else $error("wake with another card number changed state");

  chk_ldn_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    drive_set && rd_hit && !iso_read && (idx_r == IDX_LDN
    || idx_r == IDX_MEM_CTRL) |=> !o_isa.oe_n
    && o_isa.data == READ_ZERO)
    else $error("fixed-zero index read a nonzero value");

  chk_status_bit: assert property (@(posedge i_clock) disable iff (i_rst)
    drive_set && rd_hit && idx_r == IDX_STATUS
    |=> o_isa.data == {7'h00, $past(res_ready)})
    else $error("status read does not show resource ready");

  chk_range_pat: assert property (@(posedge i_clock) disable iff (i_rst)
    ior_fall && range_hit && !rd_hit |=> !o_isa.oe_n
    && o_isa.data == ($past(rc_r[RC_SEL_BIT]) ? PAT_55 : PAT_AA))
    else $error("range check answered with the wrong pattern");

  chk_range_off: assert property (@(posedge i_clock) disable iff (i_rst)
    act_r && ior_fall && !rd_hit |=> o_isa.oe_n)
    else $error("range check answered while the device is active");

  chk_iso_drive: assert property (@(posedge i_clock) disable iff (i_rst)
    ior_fall && iso_read |=> o_isa.oe_n == !$past(iso_bit)
    && (o_isa.oe_n || o_isa.data == $past(iso_pat)))
    else $error("isolation read drove the bus wrongly");

  chk_iso_step: assert property (@(posedge i_clock) disable iff (i_rst)
    iso_rise && iso_second_r && !iso_lose && iso_idx_r != ISO_LAST
    && !wake_hit |=> iso_idx_r == $past(iso_idx_r) + 7'h01)
    else $error("serial bit pointer did not advance after a pair");

  chk_cfg_guard: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_data && !in_cfg && idx_r != IDX_CTRL |=> $stable(act_r)
    && $stable(rc_r) && $stable(io_hi_r) && $stable(rom_lo_r))
    else $error("device register written outside config state");

  chk_rom_mask: assert property (@(posedge i_clock) disable iff (i_rst)
    (rom_hi_r & ~ROM_HI_WMASK) == 8'h00
    && (rom_lo_r & ~ROM_LO_WMASK) == 8'h00)
    else $error("boot rom base fixed-zero bit is set");

  chk_io_fixed: assert property (@(posedge i_clock) disable iff (i_rst)
    drive_set && rd_hit && (idx_r == IDX_IO_HI || idx_r == IDX_IO_LO)
    |=> (idx_r == IDX_IO_HI) ? o_isa.data[7:1] == 7'h01
    : o_isa.data[4:0] == 5'h00)
    else $error("io base read-only bits read wrong");

  chk_key_ports: assert property (@(posedge i_clock) disable iff (i_rst)
    waiting && ior_fall && !range_hit |=> o_isa.oe_n)
    else $error("read port answered before the key");
endmodule

// ---- ipcr_pkg.sv ----
// Constants and types shared by the plug and play configuration block
package ipcr_pkg;
  // Auto-configuration port addresses
  localparam logic [11:0] ADDR_PORT    = 12'h279;
  localparam logic [11:0] WDATA_PORT   = 12'hA79;
  localparam logic [1:0]  RD_PORT_LSB  = 2'h3;
  localparam logic [1:0]  ISA_TOP_ZERO = 2'h0;
  // Register indices
  localparam logic [7:0] IDX_RD_PORT  = 8'h00;
  localparam logic [7:0] IDX_SER_ISO  = 8'h01;
  localparam logic [7:0] IDX_CTRL     = 8'h02;
  localparam logic [7:0] IDX_WAKE     = 8'h03;
  localparam logic [7:0] IDX_RES_DATA = 8'h04;
  localparam logic [7:0] IDX_STATUS   = 8'h05;
  localparam logic [7:0] IDX_CSN      = 8'h06;
  localparam logic [7:0] IDX_LDN      = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_RANGE    = 8'h31;
  localparam logic [7:0] IDX_ROM_HI   = 8'h40;
  localparam logic [7:0] IDX_ROM_LO   = 8'h41;
  localparam logic [7:0] IDX_MEM_CTRL = 8'h42;
  localparam logic [7:0] IDX_IO_HI    = 8'h60;
  localparam logic [7:0] IDX_IO_LO    = 8'h61;
  // Field positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_WFK_BIT   = 1;
  localparam int CTRL_CSN_BIT   = 2;
  localparam int RC_SEL_BIT     = 0;
  localparam int RC_EN_BIT      = 1;
  // Writable masks and fixed values
  localparam logic [7:0] ROM_HI_WMASK   = 8'h0D;
  localparam logic [7:0] ROM_LO_WMASK   = 8'hC0;
  localparam logic [7:0] IO_HI_WMASK    = 8'h01;
  localparam logic [7:0] IO_HI_FIXED    = 8'h02;
  localparam logic [7:0] IO_LO_WMASK    = 8'hE0;
  localparam logic [7:0] LDN_VALUE      = 8'h00;
  localparam logic [7:0] MEM_CTRL_VALUE = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  // Reset values
  localparam logic [7:0] RDPORT_RST = 8'h00;
  localparam logic [7:0] CSN_RST    = 8'h00;
  localparam logic [7:0] IDX_RST    = 8'h00;
  localparam logic       ACT_RST    = 1'b0;
  localparam logic [1:0] RC_RST     = 2'h0;
  localparam logic [7:0] ROM_RST    = 8'h00;
  localparam logic [7:0] IO_RST     = 8'h00;
  // Drive and sense patterns
  localparam logic [7:0] PAT_55       = 8'h55;
  localparam logic [7:0] PAT_AA       = 8'hAA;
  localparam logic [1:0] SENSE_FIRST  = 2'h1;
  localparam logic [1:0] SENSE_SECOND = 2'h2;
  // Initiation key and serial identifier
  localparam logic [7:0] KEY_SEED    = 8'h6A;
  localparam int         KEY_LEN     = 32;
  localparam int         SERIAL_BITS = 72;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RES_FETCH_NS  = 100;
  localparam int RES_FETCH_CYC =
    (RES_FETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_WAIT_KEY, ST_SLEEP, ST_ISOLATION, ST_CONFIG
  } ipcr_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic        ior_n;
    logic        iow_n;
    logic [7:0]  data;
  } ipcr_isa_in_type;

  typedef struct packed {
    logic [7:0] data;
    logic       oe_n;
  } ipcr_isa_out_type;

  localparam ipcr_isa_in_type ISA_IDLE = '{12'h000, 1'b1, 1'b1, 8'h00};

  // Next value of the key sequence shift register
  function automatic logic [7:0] ipcr_key_next(input logic [7:0] v);
    return {v[1] ^ v[0], v[7:1]};
  endfunction
endpackage

// ---- ipcr_key_detect.sv ----
// Initiation key detector on address port writes
`timescale 1ns/100ps
module ipcr_key_detect
  import ipcr_pkg::*;
(
  // Clock and reset
  input  logic       i_clock,
  input  logic       i_rst,
  // Address port writes while waiting for the key
  input  logic       i_wr,
  input  logic [7:0] i_data,
  // One-cycle pulse when the full key was seen
  output logic       o_key_ok
);
  localparam logic [4:0] KEY_LAST = 5'(KEY_LEN - 1);

  logic [4:0] cnt_r;
  logic [7:0] exp_r;

  wire match = i_data == exp_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_r    <= 5'h00;
      exp_r    <= KEY_SEED;
      o_key_ok <= 1'b0;
    end else begin
      o_key_ok <= i_wr && match && cnt_r == KEY_LAST;
      if (i_wr && match && cnt_r == KEY_LAST) begin
        cnt_r <= 5'h00;
        exp_r <= KEY_SEED;
      end else if (i_wr && match) begin
        cnt_r <= cnt_r + 5'h01;
        exp_r <= ipcr_key_next(exp_r);
      end else if (i_wr && i_data == KEY_SEED) begin
        // A mismatch that is itself the first value restarts at step two
        cnt_r <= 5'h01;
        exp_r <= ipcr_key_next(KEY_SEED);
      end else if (i_wr) begin
        cnt_r <= 5'h00;
        exp_r <= KEY_SEED;
      end
    end
  end

  chk_key_restart: assert property (@(posedge i_clock) disable iff (i_rst)
    i_wr && !match && i_data != KEY_SEED |=> cnt_r == 5'h00 && !o_key_ok)
    else $error("key sequence not restarted on mismatch");
  chk_key_done: assert property (@(posedge i_clock) disable iff (i_rst)
    o_key_ok |-> $past(cnt_r) == KEY_LAST && $past(i_wr))
    else $error("key accepted before the full sequence");
endmodule

// ---- ipcr_res_reader.sv ----
// Resource data readout with a ready flag per byte
`timescale 1ns/100ps
module ipcr_res_reader
  import ipcr_pkg::*;
#(
  parameter int                    RES_LEN   = 11,
  parameter logic [8*RES_LEN-1:0]  RES_IMAGE = '0,
  parameter int                    FETCH_CYC = RES_FETCH_CYC
) (
  // Clock and reset
  input  logic       i_clock,
  input  logic       i_rst,
  // Control
  input  logic       i_restart,
  input  logic       i_advance,
  // Data and ready
  output logic [7:0] o_byte,
  output logic       o_ready
);
  localparam int PW = $clog2(RES_LEN + 1);
  localparam int CW = $clog2(FETCH_CYC + 1);
  localparam int RDY_DLY = FETCH_CYC;

  if (RES_LEN < 1 || FETCH_CYC < 1) begin : g_bad
    $error("resource length and fetch time must be at least one");
  end

  logic [7:0]    rom [RES_LEN];
  logic [PW-1:0] ptr_r;
  logic [CW-1:0] cnt_r;

  for (genvar k = 0; k < RES_LEN; k++) begin : g_rom
    assign rom[k] = RES_IMAGE[8*k +: 8];
  end

  wire at_end = ptr_r == PW'(RES_LEN);
  // Past the image the readout returns zero bytes
  assign o_byte = at_end ? READ_ZERO : rom[ptr_r];

  always_ff @(posedge i_clock) begin
    if (i_rst || i_restart) begin
      ptr_r   <= '0;
      cnt_r   <= '0;
      o_ready <= 1'b1;
    end else if (i_advance && o_ready) begin
      // Reads made before ready are ignored; the host polls first
      ptr_r   <= at_end ? ptr_r : ptr_r + PW'(1);
      cnt_r   <= CW'(FETCH_CYC - 1);
      o_ready <= 1'b0;
    end else if (!o_ready && cnt_r == '0) begin
      o_ready <= 1'b1;
    end else if (!o_ready) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  chk_ready_cycle: assert property (@(posedge i_clock)
    disable iff (i_rst || i_restart)
    i_advance && o_ready |=> !o_ready ##[RDY_DLY:RDY_DLY] o_ready)
    else $error("resource ready did not return on time");
endmodule

// ---- ipcr_isa_host.sv ----
// ISA host model that runs I/O cycles and resolves the SD wire
`timescale 1ns/100ps
module ipcr_isa_host
  import ipcr_pkg::*;
(
  // Clock
  input  logic             i_clock,
  // Card side of the bus
  input  ipcr_isa_out_type i_card,
  output ipcr_isa_in_type  o_bus
);
  logic [11:0] addr_r  = 12'h000;
  logic        ior_n_r = 1'b1;
  logic        iow_n_r = 1'b1;
  logic        wen_r   = 1'b0;
  logic [7:0]  wd_r    = 8'h00;
  // Undriven SD floats high on the pulled-up bus
  wire  [7:0]  sd      = wen_r ? wd_r : (i_card.oe_n ? 8'hFF : i_card.data);
  assign o_bus = '{addr_r, ior_n_r, iow_n_r, sd};

  // One I/O cycle; address and data outlast the strobe for the syncs
  task automatic cyc(input logic [11:0] a, input logic rd,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clock);
    addr_r = a;
    wd_r = d;
    wen_r = !rd;
    ior_n_r = !rd;
    iow_n_r = rd;
    repeat (6) @(negedge i_clock);
    q = sd;
    ior_n_r = 1'b1;
    iow_n_r = 1'b1;
    repeat (5) @(negedge i_clock);
    wen_r = 1'b0;
  endtask
endmodule

// ---- isa_pnp_config_registers_tb.sv ----
// Self-checking bench for the plug and play configuration registers
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin \
  cmp_count++; \
  if ((gt) !== (ex)) begin \
    failures++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); \
  end \
end
module isa_pnp_config_registers_tb;
  import ipcr_pkg::*;
  localparam logic [71:0] SID = 72'h3C_0000_0001_1234_5678;
  logic             i_clock = 1'b0;
  logic             i_rst   = 1'b1;
  int               failures  = 0;
  int               cmp_count = 0;
  ipcr_isa_in_type  bus;
  ipcr_isa_out_type card;
  ipcr_state_type   st;
  logic             act;
  logic [7:0]       rom_hi;
  logic [7:0]       rom_lo;
  logic [7:0]       io_hi;
  logic [7:0]       io_lo;
  logic [7:0]       q;
  logic [7:0]       k;
  logic [7:0]       ix [7] = '{8'h40, 8'h41, 8'h60, 8'h61, 8'h07, 8'h42, 8'h20};
  logic [7:0]       ex [7] = '{8'h0D, 8'hC0, 8'h03, 8'hE0, 8'h00, 8'h00, 8'h00};
  always #10 i_clock = ~i_clock;
  ipcr_isa_host u_host (.i_clock(i_clock), .i_card(card), .o_bus(bus));
  ipcr_config_regs #(.SERIAL_ID(SID), .RES_FETCH(40)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_isa(bus), .o_isa(card),
    .o_card_state(st), .o_device_active(act),
    .o_boot_rom_base_hi(rom_hi), .o_boot_rom_base_lo(rom_lo),
    .o_io_base_hi(io_hi), .o_io_base_lo(io_lo));
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] x;
    u_host.cyc(ADDR_PORT, 1'b0, i, x);
    u_host.cyc(WDATA_PORT, 1'b0, d, x);
  endtask
  // Read port sits at 203 once index 00 holds 80
  task automatic rd(input logic [7:0] i, output logic [7:0] d);
    logic [7:0] x;
    u_host.cyc(ADDR_PORT, 1'b0, i, x);
    u_host.cyc(12'h203, 1'b1, 8'h00, d);
  endtask
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clock);
    `CHK("state", ST_WAIT_KEY, st);
    u_host.cyc(12'h003, 1'b1, 8'h00, q);
    `CHK("locked port", 8'hFF, q);
    u_host.cyc(ADDR_PORT, 1'b0, KEY_SEED, q);
    u_host.cyc(ADDR_PORT, 1'b0, 8'h00, q);
    k = KEY_SEED;
    for (int n = 0; n < KEY_LEN; n++) begin
      u_host.cyc(ADDR_PORT, 1'b0, k, q);
      k = {k[1] ^ k[0], k[7:1]};
    end
    `CHK("state", ST_SLEEP, st);
    wr(IDX_ACTIVATE, 8'h01);
    `CHK("active", 1'b0, act);
    wr(IDX_RD_PORT, 8'h80);
    wr(IDX_WAKE, 8'h00);
    `CHK("state", ST_ISOLATION, st);
    u_host.cyc(ADDR_PORT, 1'b0, IDX_SER_ISO, q);
    for (int b = 0; b < 4; b++) begin
      u_host.cyc(12'h203, 1'b1, 8'h00, q);
      `CHK("iso first", SID[b] ? PAT_55 : 8'hFF, q);
      u_host.cyc(12'h203, 1'b1, 8'h00, q);
      `CHK("iso second", SID[b] ? PAT_AA : 8'hFF, q);
    end
    wr(IDX_CSN, 8'h05);
    `CHK("state", ST_CONFIG, st);
    rd(IDX_CSN, q);
    `CHK("card number", 8'h05, q);
    for (int b = 0; b < 2; b++) begin
      rd(IDX_STATUS, q);
      for (int t = 0; t < 20 && q[0] !== 1'b1; t++) rd(IDX_STATUS, q);
      `CHK("ready", 1'b1, q[0]);
      if (q[0] !== 1'b1) close_out();
      rd(IDX_RES_DATA, q);
      `CHK("resource", SID[8*b +: 8], q);
      rd(IDX_STATUS, q);
      `CHK("fetching", 1'b0, q[0]);
    end
    for (int n = 0; n < 7; n++) begin
      wr(ix[n], 8'hFF);
      rd(ix[n], q);
      `CHK("fixed bits", ex[n], q);
    end
    `CHK("rom base hi pin", 8'h0D, rom_hi);
    `CHK("rom base lo pin", 8'hC0, rom_lo);
    `CHK("io base hi pin", 8'h01, io_hi);
    `CHK("io base lo pin", 8'hE0, io_lo);
    wr(IDX_RANGE, 8'h03);
    u_host.cyc(12'h3E0, 1'b1, 8'h00, q);
    `CHK("range 55", PAT_55, q);
    wr(IDX_RANGE, 8'h02);
    u_host.cyc(12'h3E0, 1'b1, 8'h00, q);
    `CHK("range AA", PAT_AA, q);
    wr(IDX_RANGE, 8'h00);
    wr(IDX_ACTIVATE, 8'h01);
    `CHK("active", 1'b1, act);
    wr(IDX_CTRL, 8'h01);
    `CHK("active", 1'b0, act);
    rd(IDX_CSN, q);
    `CHK("card number", 8'h05, q);
    rd(IDX_ROM_HI, q);
    `CHK("rom base", 8'h00, q);
    rd(IDX_CTRL, q);
    `CHK("control", 8'h00, q);
    wr(IDX_ACTIVATE, 8'h01);
    `CHK("active", 1'b1, act);
    wr(IDX_CTRL, 8'h04);
    rd(IDX_CSN, q);
    `CHK("card number", 8'h00, q);
    wr(IDX_CTRL, 8'h02);
    `CHK("state", ST_WAIT_KEY, st);
    close_out();
  end
endmodule
